// *** rtl/crmv_pkg.sv ***
package crmv_pkg;

  // register map
  localparam logic [7:0] ADDR_CODE_SELECT = 8'h32;
  localparam logic [7:0] ADDR_STATE_CONTROL = 8'h35;
  localparam logic [7:0] RST_CODE_SELECT = 8'h7F;
  localparam logic [7:0] RST_STATE_CONTROL = 8'h24;

  // field positions
  localparam int STATE_LSB = 0;
  localparam int EXIT_LSB = 3;
  localparam int SOURCE_BIT = 7;
  localparam int CODE_LSB = 0;
  localparam logic [7:0] STATE_CONTROL_MASK = 8'h3F;

  // state field encodings
  localparam logic [2:0] STATE_OFF = 3'h4;
  localparam logic [2:0] STATE_PFM = 3'h5;
  localparam logic [2:0] STATE_APS = 3'h6;
  localparam logic [2:0] STATE_PWM = 3'h7;

  // voltage code scaling, microvolts
  localparam logic [31:0] STEP_UV = 32'h0000_30D4;
  localparam logic [31:0] MIN_UV = 32'h0004_93E0;
  localparam logic [31:0] MAX_UV = 32'h0012_4F80;
  localparam logic [6:0] RST_PIN_CODE = 7'h7F;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_PFM = 4'b0010,
    MODE_APS = 4'b0100,
    MODE_PWM = 4'b1000
  } crmv_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } crmv_regreq_s;

endpackage

// *** rtl/crmv_code_select.sv ***
module crmv_code_select (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // shared code pins
  input wire logic [6:0] voltage_code_pins,
  input wire logic code_latch_enable,
  // register side
  input wire logic code_source_override,
  input wire logic [6:0] host_voltage_code,
  // result
  output logic [6:0] active_code,
  output logic [31:0] target_uv
);

  logic [6:0] pin_code_q;
  logic [6:0] pin_code_d;
  logic [6:0] active_code_d;

  function automatic logic [31:0] code_to_uv(input logic [6:0] code);
    logic [31:0] uv;
    uv = crmv_pkg::MIN_UV + crmv_pkg::STEP_UV * {25'h000_0000, code};
    if (uv > crmv_pkg::MAX_UV)
    begin
      uv = crmv_pkg::MAX_UV;
    end
    return uv;
  endfunction

  // only this rail's enable captures the shared pins
  assign pin_code_d = code_latch_enable ? voltage_code_pins : pin_code_q; // [RQ9]
  assign active_code_d = code_source_override ? host_voltage_code : pin_code_q; // [RQ5]

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_code_q <= crmv_pkg::RST_PIN_CODE;
    end
    else
    begin
      pin_code_q <= pin_code_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      active_code <= crmv_pkg::RST_PIN_CODE;
      target_uv <= crmv_pkg::MAX_UV;
    end
    else
    begin
      active_code <= active_code_d;
      target_uv <= code_to_uv(active_code_d); // [RQ10]
    end
  end

  a_latch_capture: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    code_latch_enable |=> pin_code_q == $past(voltage_code_pins))
    else $error("pin code not captured on latch enable");

  a_step_scale: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    target_uv == ((crmv_pkg::MIN_UV + crmv_pkg::STEP_UV * {25'h000_0000, active_code}) > crmv_pkg::MAX_UV
      ? crmv_pkg::MAX_UV : crmv_pkg::MIN_UV + crmv_pkg::STEP_UV * {25'h000_0000, active_code}))
    else $error("target voltage does not match code");

endmodule // crmv_code_select

// *** rtl/crmv_rail_control.sv ***
// What this block does
// [RQ1] State field codes 4..7 select off, PFM, pulse skipping, PWM; 0..3 reserved.
// [RQ2] Standby-exit pin copies exit field into state; exit codes 0..3 leave it alone.
// [RQ3] Host programs the exit field after power-up before relying on it.
// [RQ4] Code register holds a 7-bit host voltage code, same encoding as pins.
// [RQ5] Code register bit 7 picks pins (0) or register code field (1).
// [RQ6] State control register at 0x35, read/write, resets to 0x24.
// [RQ7] Code select register at 0x32, read/write, resets to 0x7F.
// [RQ8] Exit field is bits 5:3; bits 7:6 read zero, ignore writes.
// [RQ9] Code pins shared with another rail; own latch enable captures them.
// [RQ10] Each code step is 12.5 mV from 0.3 V up to 1.2 V.
// [RQ11] Output discharge is on whenever the rail is off.
// [RQ12] Overcurrent limits current per cycle, raises fault flag and fault interrupt.
module crmv_rail_control (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from the serial interface
  input wire crmv_pkg::crmv_regreq_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // pins
  input wire logic [6:0] voltage_code_pins,
  input wire logic code_latch_enable,
  input wire logic standby_exit_pin,
  // analog side
  input wire logic overcurrent_detect,
  output crmv_pkg::crmv_mode_e rail_mode,
  output logic discharge_en,
  output logic current_limit_en,
  output logic [6:0] active_code,
  output logic [31:0] target_uv,
  // fault reporting
  output logic core_overcurrent_flag,
  output logic regulator_fault_irq
);

  logic [7:0] state_control_q;
  logic [7:0] state_control_d;
  logic [7:0] code_select_q;
  logic [7:0] code_select_d;
  logic exit_pin_q;
  logic exit_event;
  logic [2:0] exit_field;
  logic wr_state;
  logic wr_code;
  crmv_pkg::crmv_mode_e mode_d;

  function automatic crmv_pkg::crmv_mode_e decode_state(input logic [2:0] code);
    crmv_pkg::crmv_mode_e m;
    case (code)
      crmv_pkg::STATE_PFM: m = crmv_pkg::MODE_PFM;
      crmv_pkg::STATE_APS: m = crmv_pkg::MODE_APS;
      crmv_pkg::STATE_PWM: m = crmv_pkg::MODE_PWM;
      default: m = crmv_pkg::MODE_OFF;
    endcase
    return m;
  endfunction

  function automatic logic is_valid_state(input logic [2:0] code);
    return code[2];
  endfunction

  assign wr_state = reg_req.wr && (reg_req.addr == crmv_pkg::ADDR_STATE_CONTROL);
  assign wr_code = reg_req.wr && (reg_req.addr == crmv_pkg::ADDR_CODE_SELECT);
  assign exit_field = state_control_q[crmv_pkg::EXIT_LSB +: 3];
  assign exit_event = standby_exit_pin && !exit_pin_q;

  // exit copy overrides a same-cycle host write of the state field
  always_comb
  begin
    state_control_d = state_control_q;
    if (wr_state)
    begin
      state_control_d = reg_req.wdata & crmv_pkg::STATE_CONTROL_MASK; // [RQ8]
    end
    if (exit_event && is_valid_state(exit_field))
    begin
      state_control_d[crmv_pkg::STATE_LSB +: 3] = exit_field; // [RQ2]
    end
  end

  assign code_select_d = wr_code ? reg_req.wdata : code_select_q; // [RQ4]

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_control_q <= crmv_pkg::RST_STATE_CONTROL; // [RQ6]
    end
    else
    begin
      state_control_q <= state_control_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      code_select_q <= crmv_pkg::RST_CODE_SELECT; // [RQ7]
    end
    else
    begin
      code_select_q <= code_select_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      exit_pin_q <= 1'b0;
    end
    else
    begin
      exit_pin_q <= standby_exit_pin;
    end
  end

  // read port, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          crmv_pkg::ADDR_STATE_CONTROL: reg_rdata <= state_control_q; // [RQ6]
          crmv_pkg::ADDR_CODE_SELECT: reg_rdata <= code_select_q; // [RQ7]
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign mode_d = decode_state(state_control_q[crmv_pkg::STATE_LSB +: 3]); // [RQ1]

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rail_mode <= crmv_pkg::MODE_OFF;
      discharge_en <= 1'b1;
    end
    else
    begin
      rail_mode <= mode_d; // [RQ1]
      discharge_en <= (mode_d == crmv_pkg::MODE_OFF); // [RQ11]
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      current_limit_en <= 1'b0;
      core_overcurrent_flag <= 1'b0;
      regulator_fault_irq <= 1'b0;
    end
    else
    begin
      current_limit_en <= overcurrent_detect; // [RQ12]
      core_overcurrent_flag <= overcurrent_detect; // [RQ12]
      regulator_fault_irq <= overcurrent_detect; // [RQ12]
    end
  end

  crmv_code_select u_code_select (
    .clk(clk),
    .sys_rst(sys_rst),
    .voltage_code_pins(voltage_code_pins),
    .code_latch_enable(code_latch_enable),
    .code_source_override(code_select_q[crmv_pkg::SOURCE_BIT]),
    .host_voltage_code(code_select_q[crmv_pkg::CODE_LSB +: 7]),
    .active_code(active_code),
    .target_uv(target_uv)
  );

  // checks
  sequence s_exit_valid;
    exit_event && is_valid_state(exit_field);
  endsequence

  sequence s_state_follows;
    ##1 state_control_q[2:0] == $past(exit_field) ##1 rail_mode == decode_state($past(exit_field, 2));
  endsequence

  a_exit_copy: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    s_exit_valid |-> s_state_follows)
    else $error("exit field not copied into state");

  a_exit_nocopy: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    (exit_event && !is_valid_state(exit_field) && !wr_state) |=> $stable(state_control_q[2:0]))
    else $error("state changed on do-not-copy exit");

  a_mode_decode: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    (state_control_q[2:0] == crmv_pkg::STATE_PWM) |=> rail_mode == crmv_pkg::MODE_PWM)
    else $error("PWM code not decoded");

  a_discharge_off: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    (!$past(state_control_q[2]) || $past(state_control_q[1:0]) == 2'b00) |-> discharge_en)
    else $error("discharge not on in off state");

  a_discharge_on: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    (!$past(sys_rst) && $past(state_control_q[2]) && $past(state_control_q[1:0]) != 2'b00) |-> !discharge_en)
    else $error("discharge on while rail running");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    state_control_q[7:6] == 2'b00)
    else $error("reserved bits not zero");

  a_reset_values: assert property (@(posedge clk) // [RQ6]
    $fell(sys_rst) |-> state_control_q == crmv_pkg::RST_STATE_CONTROL && code_select_q == crmv_pkg::RST_CODE_SELECT)
    else $error("register reset value wrong");

  a_code_readback: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    (wr_code ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == crmv_pkg::ADDR_CODE_SELECT))
      |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2))
    else $error("code register readback wrong");

  a_override_src: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    (code_select_q[7] && $stable(code_select_q)) |=> active_code == $past(code_select_q[6:0]))
    else $error("override code not selected");

  a_fault_irq: assert property (@(posedge clk) disable iff (sys_rst) // [RQ12]
    overcurrent_detect |=> core_overcurrent_flag && regulator_fault_irq && current_limit_en)
    else $error("overcurrent not reported");

endmodule // crmv_rail_control

// *** test/crmv_host_model.sv ***
module crmv_host_model (
  // clock and read answer
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // requests and pins
  output crmv_pkg::crmv_regreq_s reg_req,
  output logic [6:0] voltage_code_pins,
  output logic code_latch_enable,
  output logic standby_exit_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_req = '0;
    voltage_code_pins = 7'h00;
    code_latch_enable = 1'b0;
    standby_exit_pin = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    if (reg_rvalid !== 1'b1)
      @(posedge clk) #1;
    q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
  // write, then read back on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
  // en low: code meant for the other rail
  task automatic present(input logic [6:0] c, input logic en);
    @(posedge clk);
    voltage_code_pins <= c;
    code_latch_enable <= en;
    @(posedge clk);
    code_latch_enable <= 1'b0;
    // released pins do not keep the last code
    voltage_code_pins <= ~c;
  endtask
  task automatic exit_pulse;
    @(posedge clk);
    standby_exit_pin <= 1'b1;
    @(posedge clk);
    standby_exit_pin <= 1'b0;
  endtask
endmodule // crmv_host_model

// *** test/test_core_rail_mode_vid_control.sv ***
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end

module test_core_rail_mode_vid_control;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [2:0] m;} crmv_row_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic overcurrent_detect = 1'b0;
  crmv_pkg::crmv_regreq_s reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [6:0] voltage_code_pins;
  logic code_latch_enable;
  logic standby_exit_pin;
  crmv_pkg::crmv_mode_e rail_mode;
  logic discharge_en;
  logic current_limit_en;
  logic [6:0] active_code;
  logic [31:0] target_uv;
  logic core_overcurrent_flag;
  logic regulator_fault_irq;
  logic [7:0] q;
  int mismatches = 0;
  int samples_checked = 0;
  crmv_row_s rows [7] = '{
    '{8'h35, 8'h04, 8'h04, 3'h4}, '{8'h35, 8'h25, 8'h25, 3'h5},
    '{8'h35, 8'h26, 8'h26, 3'h6}, '{8'h35, 8'hFF, 8'h3F, 3'h7},
    '{8'h35, 8'h21, 8'h21, 3'h1}, '{8'h32, 8'h85, 8'h85, 3'h1},
    '{8'h40, 8'h55, 8'h00, 3'h1}};

  crmv_rail_control i_crmv_rail_control (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .voltage_code_pins(voltage_code_pins),
    .code_latch_enable(code_latch_enable), .standby_exit_pin(standby_exit_pin),
    .overcurrent_detect(overcurrent_detect), .rail_mode(rail_mode), .discharge_en(discharge_en),
    .current_limit_en(current_limit_en), .active_code(active_code), .target_uv(target_uv),
    .core_overcurrent_flag(core_overcurrent_flag), .regulator_fault_irq(regulator_fault_irq));

  crmv_host_model i_crmv_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req), .voltage_code_pins(voltage_code_pins), .code_latch_enable(code_latch_enable),
    .standby_exit_pin(standby_exit_pin));

  function automatic crmv_pkg::crmv_mode_e mode_of(input logic [2:0] c);
    return crmv_pkg::crmv_mode_e'(c[2] ? 4'h1 << c[1:0] : 4'h1);
  endfunction
  function automatic logic [31:0] uv(input logic [6:0] c);
    logic [31:0] t;
    t = crmv_pkg::MIN_UV + crmv_pkg::STEP_UV * c;
    return (t > crmv_pkg::MAX_UV) ? crmv_pkg::MAX_UV : t;
  endfunction
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      i_crmv_host_model.wr(rows[i].a, rows[i].d);
      i_crmv_host_model.rd(rows[i].a, q);
      `CHK(q, rows[i].q)
      settle();
      `CHK(rail_mode, mode_of(rows[i].m))
      `CHK(discharge_en, rows[i].m[2:0] == 3'h4 || !rows[i].m[2])
    end
    `CHK(active_code, 7'h05)
    `CHK(target_uv, uv(7'h05))
    i_crmv_host_model.present(7'h10, 1'b1);
    settle();
    `CHK(active_code, 7'h05)
    i_crmv_host_model.wr_rd(8'h32, 8'h00, q);
    `CHK(q, 8'h00)
    settle();
    `CHK(active_code, 7'h10)
    `CHK(target_uv, uv(7'h10))
    i_crmv_host_model.present(7'h20, 1'b0);
    settle();
    `CHK(active_code, 7'h10)
    i_crmv_host_model.present(7'h50, 1'b1);
    settle();
    `CHK(target_uv, crmv_pkg::MAX_UV)
    for (int e = 0; e < 8; e++)
    begin
      i_crmv_host_model.wr(8'h35, {2'b00, e[2:0], 3'h6});
      i_crmv_host_model.exit_pulse();
      settle();
      `CHK(rail_mode, mode_of(e[2] ? e[2:0] : 3'h6))
      i_crmv_host_model.rd(8'h35, q);
      `CHK(q, {2'b00, e[2:0], e[2] ? e[2:0] : 3'h6})
    end
    @(posedge clk);
    overcurrent_detect <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({current_limit_en, core_overcurrent_flag, regulator_fault_irq}, 3'h7)
    @(posedge clk);
    overcurrent_detect <= 1'b0;
    settle();
    `CHK({current_limit_en, core_overcurrent_flag, regulator_fault_irq}, 3'h0)
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(rail_mode, crmv_pkg::MODE_OFF)
    `CHK(discharge_en, 1'b1)
    `CHK(active_code, 7'h7F)
    i_crmv_host_model.rd(8'h35, q);
    `CHK(q, 8'h24)
    i_crmv_host_model.rd(8'h32, q);
    `CHK(q, 8'h7F)
    report_and_stop();
  end
endmodule // test_core_rail_mode_vid_control
